/* File: pkg/sim_defines.svh */
/*
 timing counts and reset values for the safety input interlock monitor.
 assumes a 100 MHz core clock.
*/
`ifndef SIM_DEFINES_SVH
`define SIM_DEFINES_SVH
`define SIM_CLK_PERIOD_NS   10
`define SIM_SIMUL_WIN_MS    500
`define SIM_SIMUL_WIN_CYC   ((`SIM_SIMUL_WIN_MS * 1000000) / `SIM_CLK_PERIOD_NS)
`define SIM_OUT_RST         1'b0
`define SIM_LATCH_RST       1'b1
`define SIM_SYNC_RST        7'h13
`define SIM_START_PREV_RST  1'b1
`endif

/* File: pkg/sim_pkg.sv */
/*
 types for the safety input interlock monitor.
 assumes nothing of its surroundings.
*/
package sim_pkg;
    typedef enum logic [2:0] {
        THI_IDLE,
        THI_WAIT_SECOND,
        THI_ACTIVE,
        THI_WAIT_RELEASE
    } sim_thi_state_t;

    typedef enum logic [1:0] {
        GRD_STOPPED,
        GRD_RUNNING
    } sim_grd_state_t;
endpackage

/* File: rtl/sim_safety_input_interlock_monitor.sv */
/*
 safety input interlock monitor: two-hand initiation, guard monitoring, latched stop.
 assumes active-high pin inputs from outside the clock domain, synchronised here;
 the machine control outside provides anti-repeat control.
 hand and start synchronisers reset to the actuated level, so a control held
 through reset reads as held and cannot start anything.
*/
//
// Contract
// - accept two-hand initiation only if both hands actuate within 500 ms
// - on window expiry, withhold initiation until both hands are released
// - two-hand output stays on only while both hands stay actuated
// - two-hand output turns off as soon as either hand releases
// - after cessation, both hands must release then actuate again
// - hazard output off while guard open; stop at once if guard opens
// - guard closing alone never turns on the hazard output
// - pass-through mode latches off after gate or optical stop
// - latched off clears only by dedicated reset, separate from start
`timescale 1ns/10ps
`include "sim_defines.svh"

module sim_safety_input_interlock_monitor #(
    parameter int unsigned SIMUL_WIN_CYC = `SIM_SIMUL_WIN_CYC
) (
    input  wire logic CORE_CLK_I,
    input  wire logic NRST_I,
    input  wire logic HAND_A_I,
    input  wire logic HAND_B_I,
    input  wire logic GUARD_CLOSED_I,
    input  wire logic OPTICAL_CLEAR_I,
    input  wire logic START_I,
    input  wire logic LATCH_RESET_I,
    input  wire logic PASS_THROUGH_MODE_I,
    output logic      TWO_HAND_INITIATION_O,
    output logic      MACHINE_PRIMARY_CONTROL_ELEMENT_O,
    output logic      LATCHED_OFF_O
);
    import sim_pkg::*;

    localparam int unsigned TW = $clog2(SIMUL_WIN_CYC + 1);

    // both hand controls released
    function automatic logic both_released(input logic a, input logic b);
        return !a && !b;
    endfunction

    // both hand controls actuated
    function automatic logic both_actuated(input logic a, input logic b);
        return a && b;
    endfunction

    // two-flop synchronisers for all pins
    logic [6:0] sync1_ff;
    logic [6:0] sync2_ff;
    logic [6:0] nxt_sync1;
    logic [6:0] nxt_sync2;
    logic       hand_a;
    logic       hand_b;
    logic       guard_closed;
    logic       optical_clear;
    logic       start_in;
    logic       latch_rst_in;
    logic       pt_mode;

    always_comb begin
        nxt_sync1 = {PASS_THROUGH_MODE_I,
                     LATCH_RESET_I,
                     START_I,
                     OPTICAL_CLEAR_I,
                     GUARD_CLOSED_I,
                     HAND_B_I,
                     HAND_A_I};
        nxt_sync2 = sync1_ff;
    end

    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            sync1_ff <= `SIM_SYNC_RST;
            sync2_ff <= `SIM_SYNC_RST;
        end else begin
            sync1_ff <= nxt_sync1;
            sync2_ff <= nxt_sync2;
        end
    end

    assign {pt_mode,
            latch_rst_in,
            start_in,
            optical_clear,
            guard_closed,
            hand_b,
            hand_a} = sync2_ff;

    // two-hand state machine
    sim_thi_state_t thi_state_ff;
    sim_thi_state_t nxt_thi_state;
    logic [TW-1:0]  win_cnt_ff;
    logic [TW-1:0]  nxt_win_cnt;
    logic           thi_out_ff;
    logic           nxt_thi_out;

    always_comb begin
        nxt_thi_state = thi_state_ff;
        nxt_win_cnt   = win_cnt_ff;
        nxt_thi_out   = 1'b0;
        case (thi_state_ff)
            THI_IDLE: begin
                if (both_actuated(hand_a, hand_b)) begin
                    nxt_thi_state = THI_ACTIVE;
                    nxt_thi_out   = 1'b1;
                end else if (hand_a || hand_b) begin
                    nxt_thi_state = THI_WAIT_SECOND;
                    nxt_win_cnt   = TW'(1);
                end
            end
            THI_WAIT_SECOND: begin
                if (both_released(hand_a, hand_b)) begin
                    nxt_thi_state = THI_IDLE;
                end else if (both_actuated(hand_a, hand_b) &&
                             win_cnt_ff <= TW'(SIMUL_WIN_CYC)) begin
                    nxt_thi_state = THI_ACTIVE;
                    nxt_thi_out   = 1'b1;
                end else if (win_cnt_ff >= TW'(SIMUL_WIN_CYC)) begin
                    nxt_thi_state = THI_WAIT_RELEASE;
                end else begin
                    nxt_win_cnt = win_cnt_ff + TW'(1);
                end
            end
            THI_ACTIVE: begin
                if (both_actuated(hand_a, hand_b)) begin
                    nxt_thi_out = 1'b1;
                end else begin
                    nxt_thi_state = THI_WAIT_RELEASE;
                end
            end
            THI_WAIT_RELEASE: begin
                if (both_released(hand_a, hand_b)) begin
                    nxt_thi_state = THI_IDLE;
                end
            end
            default: begin
                nxt_thi_state = THI_WAIT_RELEASE;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            thi_state_ff <= THI_WAIT_RELEASE;
            win_cnt_ff   <= '0;
            thi_out_ff   <= `SIM_OUT_RST;
        end else begin
            thi_state_ff <= nxt_thi_state;
            win_cnt_ff   <= nxt_win_cnt;
            thi_out_ff   <= nxt_thi_out;
        end
    end

    // guard and optical monitoring with latched stop
    sim_grd_state_t grd_state_ff;
    sim_grd_state_t nxt_grd_state;
    logic           latch_ff;
    logic           nxt_latch;
    logic           haz_out_ff;
    logic           nxt_haz_out;
    // start edge reference; resets high so a start held through reset is no edge
    logic           start_prev_ff;
    logic           safe_ok;
    logic           start_edge;

    always_comb begin
        safe_ok       = guard_closed && optical_clear;
        start_edge    = start_in && !start_prev_ff;
        nxt_grd_state = grd_state_ff;
        nxt_latch     = latch_ff;
        nxt_haz_out   = 1'b0;
        if (!safe_ok) begin
            nxt_grd_state = GRD_STOPPED;
            if (pt_mode) begin
                nxt_latch = 1'b1;
            end
        end else if (latch_ff) begin
            if (latch_rst_in) begin
                nxt_latch = 1'b0;
            end
        end else begin
            case (grd_state_ff)
                GRD_STOPPED: begin
                    if (start_edge && !latch_rst_in) begin
                        nxt_grd_state = GRD_RUNNING;
                    end
                end
                GRD_RUNNING: begin
                    nxt_haz_out = 1'b1;
                end
                default: begin
                    nxt_grd_state = GRD_STOPPED;
                end
            endcase
            if (nxt_grd_state == GRD_RUNNING) begin
                nxt_haz_out = 1'b1;
            end
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            grd_state_ff  <= GRD_STOPPED;
            latch_ff      <= `SIM_LATCH_RST;
            haz_out_ff    <= `SIM_OUT_RST;
            start_prev_ff <= `SIM_START_PREV_RST;
        end else begin
            grd_state_ff  <= nxt_grd_state;
            latch_ff      <= nxt_latch;
            haz_out_ff    <= nxt_haz_out;
            start_prev_ff <= start_in;
        end
    end

    assign TWO_HAND_INITIATION_O             = thi_out_ff;
    assign MACHINE_PRIMARY_CONTROL_ELEMENT_O = haz_out_ff;
    assign LATCHED_OFF_O                     = latch_ff;
endmodule

/* File: dv/sim_monitor_properties.sv */
/* port checker for the interlock monitor.
   bound by name to the top module; hands, guard and start are synchronised inside. */
`timescale 1ns/10ps
module sim_monitor_props (
    input wire logic CORE_CLK_I,
    input wire logic NRST_I,
    input wire logic HAND_A_I,
    input wire logic HAND_B_I,
    input wire logic GUARD_CLOSED_I,
    input wire logic OPTICAL_CLEAR_I,
    input wire logic START_I,
    input wire logic LATCH_RESET_I,
    input wire logic PASS_THROUGH_MODE_I,
    input wire logic TWO_HAND_INITIATION_O,
    input wire logic MACHINE_PRIMARY_CONTROL_ELEMENT_O,
    input wire logic LATCHED_OFF_O
);
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!NRST_I);
    hand_drop_a: assert property (
        (!HAND_A_I || !HAND_B_I) |-> ##3 !TWO_HAND_INITIATION_O)
        else $error("two-hand output held after release");
    hand_both_a: assert property (
        $rose(TWO_HAND_INITIATION_O) |-> $past(HAND_A_I, 3) && $past(HAND_B_I, 3))
        else $error("two-hand output without both hands");
    fresh_press_a: assert property (
        $rose(TWO_HAND_INITIATION_O) |-> !$past(HAND_A_I, 4) || !$past(HAND_B_I, 4))
        else $error("two-hand output without new press");
    guard_stop_a: assert property (
        (!GUARD_CLOSED_I || !OPTICAL_CLEAR_I) |-> ##3 !MACHINE_PRIMARY_CONTROL_ELEMENT_O)
        else $error("hazard output on while unsafe");
    pass_latch_a: assert property (
        (!(GUARD_CLOSED_I && OPTICAL_CLEAR_I) && PASS_THROUGH_MODE_I) |-> ##3 LATCHED_OFF_O)
        else $error("stop not latched");
    latch_block_a: assert property (
        LATCHED_OFF_O |-> !MACHINE_PRIMARY_CONTROL_ELEMENT_O)
        else $error("hazard output on while latched");
    latch_clear_a: assert property (
        $fell(LATCHED_OFF_O) |-> $past(LATCH_RESET_I, 3))
        else $error("latch cleared without reset input");
    start_edge_a: assert property (
        $rose(MACHINE_PRIMARY_CONTROL_ELEMENT_O) |-> $past(START_I, 3) && !$past(START_I, 4))
        else $error("hazard output on without start edge");
    cover property ($rose(TWO_HAND_INITIATION_O));
    cover property ($rose(MACHINE_PRIMARY_CONTROL_ELEMENT_O));
    cover property ($rose(LATCHED_OFF_O));
    cover property ($fell(LATCHED_OFF_O));
endmodule
bind sim_safety_input_interlock_monitor sim_monitor_props chk_u (
    .CORE_CLK_I                        (CORE_CLK_I),
    .NRST_I                            (NRST_I),
    .HAND_A_I                          (HAND_A_I),
    .HAND_B_I                          (HAND_B_I),
    .GUARD_CLOSED_I                    (GUARD_CLOSED_I),
    .OPTICAL_CLEAR_I                   (OPTICAL_CLEAR_I),
    .START_I                           (START_I),
    .LATCH_RESET_I                     (LATCH_RESET_I),
    .PASS_THROUGH_MODE_I               (PASS_THROUGH_MODE_I),
    .TWO_HAND_INITIATION_O             (TWO_HAND_INITIATION_O),
    .MACHINE_PRIMARY_CONTROL_ELEMENT_O (MACHINE_PRIMARY_CONTROL_ELEMENT_O),
    .LATCHED_OFF_O                     (LATCHED_OFF_O)
);

/* File: dv/sim_field_model.sv */
/* machine control model: one bounded start pulse per request.
   request sampled on the falling edge. */
`timescale 1ns/10ps
module sim_field_model (
    input  wire logic clk_i,
    input  wire logic go_i,
    output logic      start_o
);
    logic [2:0] cnt_ff = 3'h0;
    always @(negedge clk_i) begin
        if (go_i && cnt_ff == 3'h0) cnt_ff <= 3'h5;
        else if (cnt_ff != 3'h0) cnt_ff <= cnt_ff - 3'h1;
    end
    assign start_o = cnt_ff > 3'h1;
endmodule

/* File: dv/sim_safety_input_interlock_monitor_tb.sv */
/* self-checking bench for the interlock monitor.
   small window count; start comes from the field model. */
`timescale 1ns/10ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin miscompares++; \
    $display("unexpected t=%0t got %h exp %h", $time, a, e); end end
module safety_input_interlock_monitor_tb;
    localparam int WIN = 20;
    logic clk, nrst, ha, hb, grd, opt, go, st, lrst, ptm, th, machine_primary_control_element, lat;
    int   miscompares = 0, cmp_count = 0;
    int   rows[5][2] = '{'{0, 1}, '{WIN - 2, 1}, '{WIN, 1}, '{WIN + 1, 0}, '{WIN + 2, 0}};
    sim_safety_input_interlock_monitor #(.SIMUL_WIN_CYC(WIN)) dut_u (.CORE_CLK_I(clk),
        .NRST_I(nrst), .HAND_A_I(ha), .HAND_B_I(hb), .GUARD_CLOSED_I(grd),
        .OPTICAL_CLEAR_I(opt), .START_I(st), .LATCH_RESET_I(lrst), .PASS_THROUGH_MODE_I(ptm),
        .TWO_HAND_INITIATION_O(th), .MACHINE_PRIMARY_CONTROL_ELEMENT_O(machine_primary_control_element), .LATCHED_OFF_O(lat));
    sim_field_model mdl_u (.clk_i(clk), .go_i(go), .start_o(st));
    task tk(int n); repeat (n) @(negedge clk); endtask
    task strt; go <= 1'b1; tk(1); go <= 1'b0; tk(8); endtask
    task clr; lrst = 1'b1; tk(2); lrst = 1'b0; tk(4); endtask
    task summarize;
        if (miscompares == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin clk = 1'b0; forever #5 clk = ~clk; end
    initial begin tk(4000); miscompares++; summarize(); end
    initial begin
        {nrst, ha, hb, go, lrst} = 5'h0; {grd, opt, ptm} = 3'h7;
        tk(2); `CHK({th, machine_primary_control_element, lat}, 3'h1)
        tk(2); nrst = 1'b1; tk(2);
        for (int i = 0; i < 5; i++) begin
            ha = 1'b1; tk(rows[i][0]); hb = 1'b1; tk(5);
            `CHK(th, rows[i][1][0])
            {ha, hb} = 2'h0; tk(4);
        end
        ha = 1'b1; tk(WIN + 3); hb = 1'b1; tk(5); hb = 1'b0; tk(2); hb = 1'b1; tk(5);
        `CHK(th, 1'b0)
        {ha, hb} = 2'h0; tk(3); {ha, hb} = 2'h3; tk(5);
        `CHK(th, 1'b1)
        hb = 1'b0; tk(4);
        `CHK(th, 1'b0)
        hb = 1'b1; tk(5);
        `CHK(th, 1'b0)
        {ha, hb} = 2'h0; strt();
        `CHK(machine_primary_control_element, 1'b0)
        lrst = 1'b1; tk(2); strt(); lrst = 1'b0; tk(4);
        `CHK({machine_primary_control_element, lat}, 2'h0)
        strt(); `CHK(machine_primary_control_element, 1'b1)
        grd = 1'b0; tk(4); grd = 1'b1; tk(5);
        `CHK({machine_primary_control_element, lat}, 2'h1)
        clr(); strt(); opt = 1'b0; tk(4); opt = 1'b1; tk(5);
        `CHK({machine_primary_control_element, lat}, 2'h1)
        ptm = 1'b0; clr(); strt(); grd = 1'b0; tk(4); grd = 1'b1; tk(5);
        `CHK({machine_primary_control_element, lat}, 2'h0)
        {ha, hb} = 2'h3; nrst = 1'b0; tk(1); `CHK({th, machine_primary_control_element, lat}, 3'h1)
        nrst = 1'b1; tk(6); `CHK(th, 1'b0)
        {ha, hb} = 2'h0; tk(3); {ha, hb} = 2'h3; tk(5); `CHK(th, 1'b1)
        summarize();
    end
endmodule
